//--- design/bsq_sequencer.sv
// Boost start-up sequencer, fault supervisor and switch-node timing
// What this block does
// - Shutdown high stops everything, pins inactive
// - Shutdown high keeps supply switch open
// - Start runs six ordered states
// - Normal holds until shutdown, fault or restart request
// - Soft inrush: switch as current source
// - Switch enable state: switch fully on
// - Switching starts at soft boost, 2.048ms each
// - Current limit 25, 50, 75 percent
// - Normal after 8.32ms, limit 100 percent
// - Faults may restart or stop any state
// - Undervoltage disables pins until supply recovers
// - Overcurrent disables switches, restarts at once
// - Overvoltage holds off until output recovers
// - Overtemperature holds off until temperature recovers
// - Minimum off-time every switching period
// - Skip pulses while output above target
// - Select chooses feedback input and ground pin
// - External sync only above about 300kHz
// - Sync falling edge times switch falling edge
// - Internal oscillator sets 1MHz otherwise
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
module bsq_sequencer #(
  parameter int INRUSH_CYC = bsq_pkg::INRUSH_CYC,
  parameter int SOFT_CYC   = bsq_pkg::SOFT_CYC
) (
  // Clock, reset, enable
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          clk_en,
  // AXI4-Lite write
  input  wire logic [bsq_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [bsq_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Host pins
  input  wire logic                          shutdown_input_n,
  input  wire logic                          select_in,
  input  wire logic                          sync_clock_input,
  // Analog monitors
  input  wire bsq_pkg::bsq_monitor_type      monitor_in,
  // Power stage drive
  output logic                               supply_switch_limited,
  output logic                               supply_switch_full,
  output logic                               switch_node,
  output logic [6:0]                         current_limit_pct,
  output logic                               io_active,
  // Feedback pins
  output logic                               feedback_pin_zero_out,
  output logic                               feedback_pin_zero_oe_n,
  output logic                               feedback_pin_one_out,
  output logic                               feedback_pin_one_oe_n,
  output logic                               feedback_sense_sel
);

  localparam int MIN_OFF = bsq_pkg::MIN_OFF_CYC;
  localparam int SYNC_MAX = bsq_pkg::SYNC_MAX_CYC;
  localparam int SEQ_TOTAL =
    INRUSH_CYC + bsq_pkg::SWEN_CYC + 3 * SOFT_CYC;

  function automatic logic [6:0] limit_pct(bsq_pkg::bsq_state_type s);
    case (s)
      bsq_pkg::ST_SB25:   limit_pct = bsq_pkg::LIMIT_25;
      bsq_pkg::ST_SB50:   limit_pct = bsq_pkg::LIMIT_50;
      bsq_pkg::ST_SB75:   limit_pct = bsq_pkg::LIMIT_75;
      bsq_pkg::ST_NORMAL: limit_pct = bsq_pkg::LIMIT_100;
      default:            limit_pct = bsq_pkg::LIMIT_0;
    endcase
  endfunction

  // Pin synchronisers, first stage read only by the second
  logic [10:0]               pin_meta_reg;
  logic [10:0]               pin_sync_reg;
  logic                      shut_s;
  logic                      sel_s;
  logic                      sync_s;
  logic                      above_s;
  bsq_pkg::bsq_monitor_type  mon_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= bsq_pkg::PIN_SYNC_RST;
      pin_sync_reg <= bsq_pkg::PIN_SYNC_RST;
    end else if (clk_en) begin
      pin_meta_reg <= {monitor_in, sync_clock_input, select_in,
                       shutdown_input_n};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign shut_s  = pin_sync_reg[0];
  assign sel_s   = pin_sync_reg[1];
  assign sync_s  = pin_sync_reg[2];
  assign mon_s   = bsq_pkg::bsq_monitor_type'(pin_sync_reg[10:3]);
  assign above_s = mon_s.above_target;

  // Control register
  logic ctrl_sync_allow_reg;
  logic ctrl_restart_reg;

  // Sequencer
  bsq_pkg::bsq_state_type state_reg;
  bsq_pkg::bsq_state_type state_next;
  bsq_pkg::bsq_wait_type  wait_reg;
  bsq_pkg::bsq_wait_type  wait_next;
  logic [15:0]            timer_reg;
  logic                   seq_restart;
  logic                   in_seq;

  assign in_seq = (state_reg != bsq_pkg::ST_OFF) &&
                  (state_reg != bsq_pkg::ST_FAULT);

  always_comb begin
    state_next  = state_reg;
    wait_next   = wait_reg;
    seq_restart = 1'b0;
    if (shut_s) begin
      state_next = bsq_pkg::ST_OFF;
      wait_next  = bsq_pkg::WAIT_NONE;
    end else if (mon_s.supply_below_off) begin
      state_next = bsq_pkg::ST_FAULT;
      wait_next  = bsq_pkg::WAIT_UV;
    end else if (mon_s.overtemp) begin
      state_next = bsq_pkg::ST_FAULT;
      wait_next  = bsq_pkg::WAIT_OT;
    end else if (mon_s.overvoltage) begin
      state_next = bsq_pkg::ST_FAULT;
      wait_next  = bsq_pkg::WAIT_OV;
    end else if (in_seq && (mon_s.overcurrent || ctrl_restart_reg)) begin
      state_next  = bsq_pkg::ST_INRUSH;
      seq_restart = 1'b1;
    end else begin
      case (state_reg)
        bsq_pkg::ST_OFF: state_next = bsq_pkg::ST_INRUSH;
        bsq_pkg::ST_INRUSH:
          if (timer_reg == 16'(INRUSH_CYC - 1))
            state_next = bsq_pkg::ST_SW_EN;
        bsq_pkg::ST_SW_EN:
          if (timer_reg == 16'(bsq_pkg::SWEN_CYC - 1))
            state_next = bsq_pkg::ST_SB25;
        bsq_pkg::ST_SB25:
          if (timer_reg == 16'(SOFT_CYC - 1))
            state_next = bsq_pkg::ST_SB50;
        bsq_pkg::ST_SB50:
          if (timer_reg == 16'(SOFT_CYC - 1))
            state_next = bsq_pkg::ST_SB75;
        bsq_pkg::ST_SB75:
          if (timer_reg == 16'(SOFT_CYC - 1))
            state_next = bsq_pkg::ST_NORMAL;
        bsq_pkg::ST_NORMAL: state_next = bsq_pkg::ST_NORMAL;
        bsq_pkg::ST_FAULT: begin
          if ((wait_reg == bsq_pkg::WAIT_UV && mon_s.supply_at_on) ||
              (wait_reg == bsq_pkg::WAIT_OV && mon_s.output_recovered) ||
              (wait_reg == bsq_pkg::WAIT_OT && mon_s.temp_recovered) ||
              (wait_reg == bsq_pkg::WAIT_NONE)) begin
            state_next = bsq_pkg::ST_INRUSH;
            wait_next  = bsq_pkg::WAIT_NONE;
          end
        end
        default: state_next = bsq_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= bsq_pkg::ST_OFF;
      wait_reg  <= bsq_pkg::WAIT_NONE;
    end else if (clk_en) begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
    end
  end

  // Timer restarts on every state change and every forced restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_reg <= 16'h0000;
    end else if (clk_en) begin
      if (shut_s || seq_restart || state_next != state_reg)
        timer_reg <= 16'h0000;
      else if (timer_reg != 16'hFFFF)
        timer_reg <= timer_reg + 16'h0001;
    end
  end

  // Power switch and pin drive
  logic switching;
  logic io_ok;
  assign switching = (state_reg == bsq_pkg::ST_SB25) ||
                     (state_reg == bsq_pkg::ST_SB50) ||
                     (state_reg == bsq_pkg::ST_SB75) ||
                     (state_reg == bsq_pkg::ST_NORMAL);
  assign supply_switch_limited = (state_reg == bsq_pkg::ST_INRUSH);
  assign supply_switch_full = switching ||
                              (state_reg == bsq_pkg::ST_SW_EN);
  assign io_ok = !shut_s && (state_reg != bsq_pkg::ST_OFF) &&
                 !(state_reg == bsq_pkg::ST_FAULT &&
                   wait_reg == bsq_pkg::WAIT_UV);
  assign feedback_pin_zero_out = 1'b0;
  assign feedback_pin_one_out  = 1'b0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_active              <= 1'b0;
      feedback_pin_zero_oe_n <= 1'b1;
      feedback_pin_one_oe_n  <= 1'b1;
      feedback_sense_sel     <= 1'b0;
      current_limit_pct      <= bsq_pkg::LIMIT_0;
    end else if (clk_en) begin
      io_active              <= io_ok;
      feedback_pin_zero_oe_n <= !(io_ok && sel_s);
      feedback_pin_one_oe_n  <= !(io_ok && !sel_s);
      feedback_sense_sel     <= sel_s;
      current_limit_pct      <= limit_pct(state_reg);
    end
  end

  // Oscillator and sync detector
  logic [4:0] osc_cnt_reg;
  logic       osc_wrap;
  logic       sync_prev_reg;
  logic       sync_fall;
  logic [6:0] sync_gap_reg;
  logic       sync_locked_reg;

  assign osc_wrap  = (osc_cnt_reg == 5'(bsq_pkg::OSC_PERIOD_CYC - 1));
  assign sync_fall = sync_prev_reg && !sync_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt_reg <= 5'h00;
    end else if (clk_en) begin
      osc_cnt_reg <= osc_wrap ? 5'h00 : osc_cnt_reg + 5'h01;
    end
  end

  // Slow or static sync drops lock; a fast one gains it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_prev_reg   <= 1'b1;
      sync_gap_reg    <= 7'h00;
      sync_locked_reg <= 1'b0;
    end else if (clk_en) begin
      sync_prev_reg <= sync_s;
      if (sync_fall) begin
        sync_gap_reg    <= 7'h00;
        sync_locked_reg <= ctrl_sync_allow_reg &&
                           (sync_gap_reg <= 7'(SYNC_MAX));
      end else begin
        if (sync_gap_reg != 7'h7F)
          sync_gap_reg <= sync_gap_reg + 7'h01;
        if (sync_gap_reg >= 7'(SYNC_MAX) || !ctrl_sync_allow_reg)
          sync_locked_reg <= 1'b0;
      end
    end
  end

  // Switch-node pulse generator
  logic       period_start;
  logic [4:0] off_cnt_reg;
  logic [4:0] on_cnt_reg;
  logic [4:0] on_max;
  logic       armed_reg;
  logic [11:0] on_prod;
  logic       sw_run;

  // Gate drops on the same edge the state leaves switching
  assign sw_run = switching && !seq_restart &&
                  (state_next != bsq_pkg::ST_OFF) &&
                  (state_next != bsq_pkg::ST_FAULT);
  assign period_start = sync_locked_reg ? sync_fall : osc_wrap;
  // On window scales with the limit step, never eating the off-time
  assign on_prod = 12'(bsq_pkg::OSC_PERIOD_CYC - MIN_OFF) *
                   {5'h00, limit_pct(state_reg)};
  assign on_max  = 5'(on_prod / 12'h064);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switch_node <= 1'b0;
      off_cnt_reg <= 5'h00;
      on_cnt_reg  <= 5'h00;
      armed_reg   <= 1'b0;
    end else if (clk_en) begin
      if (!sw_run) begin
        switch_node <= 1'b0;
        armed_reg   <= 1'b0;
        off_cnt_reg <= 5'(MIN_OFF);
      end else if (period_start) begin
        switch_node <= 1'b0;
        off_cnt_reg <= 5'(MIN_OFF);
        armed_reg   <= 1'b1;
      end else if (switch_node) begin
        on_cnt_reg <= on_cnt_reg + 5'h01;
        if (on_cnt_reg >= on_max - 5'h01)
          switch_node <= 1'b0;
      end else if (off_cnt_reg != 5'h00) begin
        off_cnt_reg <= off_cnt_reg - 5'h01;
      end else if (armed_reg && !above_s) begin
        switch_node <= 1'b1;
        on_cnt_reg  <= 5'h00;
        armed_reg   <= 1'b0;
      end
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  logic                        aw_got_reg;
  logic                        w_got_reg;
  logic [bsq_pkg::ADDR_W-1:0]  awaddr_reg;
  logic [31:0]                 wdata_reg;
  logic [3:0]                  wstrb_reg;
  logic [31:0]                 status_word;

  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg          <= 1'b0;
      w_got_reg           <= 1'b0;
      awaddr_reg          <= '0;
      wdata_reg           <= 32'h0000_0000;
      wstrb_reg           <= 4'h0;
      s_axi_bvalid        <= 1'b0;
      s_axi_bresp         <= bsq_pkg::RESP_OKAY;
      ctrl_sync_allow_reg <= bsq_pkg::CTRL_SYNC_ALLOW_RST;
      ctrl_restart_reg    <= 1'b0;
    end else if (clk_en) begin
      ctrl_restart_reg <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (aw_got_reg && w_got_reg) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= bsq_pkg::RESP_OKAY;
        if ({awaddr_reg[3:2], 2'b00} == bsq_pkg::REG_CTRL) begin
          if (wstrb_reg[0]) begin
            ctrl_sync_allow_reg <=
              wdata_reg[bsq_pkg::CTRL_SYNC_ALLOW_BIT];
            ctrl_restart_reg <= wdata_reg[bsq_pkg::CTRL_RESTART_BIT];
          end
        end else if ({awaddr_reg[3:2], 2'b00} != bsq_pkg::REG_STATUS) begin
          s_axi_bresp <= bsq_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[bsq_pkg::STAT_STATE_LSB +: 3] = state_reg;
    status_word[bsq_pkg::STAT_WAIT_LSB +: 2]  = wait_reg;
    status_word[bsq_pkg::STAT_LOCK_BIT]       = sync_locked_reg;
    status_word[bsq_pkg::STAT_SW_BIT]         = switching;
    status_word[bsq_pkg::STAT_IO_BIT]         = io_active;
    status_word[bsq_pkg::STAT_LIMIT_LSB +: 7] = current_limit_pct;
    status_word[bsq_pkg::STAT_MON_LSB +: 8]   = mon_s;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= bsq_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= bsq_pkg::RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case ({s_axi_araddr[3:2], 2'b00})
          bsq_pkg::REG_CTRL:
            s_axi_rdata[bsq_pkg::CTRL_SYNC_ALLOW_BIT] <= ctrl_sync_allow_reg;
          bsq_pkg::REG_STATUS: s_axi_rdata <= status_word;
          default: s_axi_rresp <= bsq_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks; frozen cycles are excluded
  logic [19:0] elapsed_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elapsed_reg <= 20'h0_0000;
    end else if (clk_en) begin
      if (!in_seq || seq_restart)
        elapsed_reg <= 20'h0_0000;
      else if (state_reg != bsq_pkg::ST_NORMAL)
        elapsed_reg <= elapsed_reg + 20'h0_0001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);

  chk_shutdown_off: assert property (shut_s |=> state_reg ==
    bsq_pkg::ST_OFF && !switch_node) else $error("shutdown ignored");
  chk_off_switch_open: assert property (state_reg == bsq_pkg::ST_OFF |->
    !supply_switch_limited && !supply_switch_full)
    else $error("switch closed while off");
  chk_seq_order: assert property ($rose(state_reg == bsq_pkg::ST_SW_EN)
    |-> $past(state_reg) == bsq_pkg::ST_INRUSH)
    else $error("bad state order");
  chk_normal_hold: assert property (state_reg == bsq_pkg::ST_NORMAL &&
    !shut_s && !mon_s.supply_below_off && !mon_s.overtemp &&
    !mon_s.overvoltage && !mon_s.overcurrent && !ctrl_restart_reg
    |=> state_reg == bsq_pkg::ST_NORMAL) else $error("left normal");
  chk_soft_drive: assert property (state_reg == bsq_pkg::ST_INRUSH |->
    supply_switch_limited && !supply_switch_full && !switch_node)
    else $error("inrush drive wrong");
  chk_limit_step: assert property (state_reg == bsq_pkg::ST_SB50 |=>
    current_limit_pct == bsq_pkg::LIMIT_50)
    else $error("limit step wrong");
  chk_normal_time: assert property ($rose(state_reg == bsq_pkg::ST_NORMAL)
    |-> elapsed_reg == 20'(SEQ_TOTAL)) else $error("start time wrong");
  chk_oc_restart: assert property (seq_restart |=> state_reg ==
    bsq_pkg::ST_INRUSH && timer_reg == 16'h0000 && !switch_node)
    else $error("restart wrong");
  chk_uv_pins: assert property (mon_s.supply_below_off && !shut_s |=>
    ##1 !io_active && feedback_pin_zero_oe_n && feedback_pin_one_oe_n)
    else $error("pins active in undervoltage");
  chk_ov_hold: assert property (state_reg == bsq_pkg::ST_FAULT &&
    wait_reg == bsq_pkg::WAIT_OV && !mon_s.output_recovered && !shut_s
    |=> state_reg == bsq_pkg::ST_FAULT) else $error("left ov wait");
  chk_min_off: assert property ($fell(switch_node) |->
    !switch_node ##1 !switch_node) else $error("off-time short");
  chk_skip_pulse: assert property ($rose(switch_node) |-> !$past(above_s))
    else $error("pulse above target");
  chk_fb_select: assert property ($past(io_ok) && $past(sel_s) |->
    !feedback_pin_zero_oe_n && feedback_pin_one_oe_n)
    else $error("feedback roles wrong");
  chk_sync_lock: assert property ($rose(sync_locked_reg) |->
    $past(sync_gap_reg) <= 7'(SYNC_MAX)) else $error("slow sync");
  chk_sync_fall: assert property (sync_locked_reg && sync_fall &&
    switching |=> !switch_node) else $error("fall not synced");

  cov_reach_normal: cover property (state_reg == bsq_pkg::ST_NORMAL);
  cov_oc_restart:   cover property (seq_restart && state_reg ==
    bsq_pkg::ST_SB75);
  cov_sync_locked:  cover property (sync_locked_reg && switch_node);
  cov_ot_recover:   cover property (wait_reg == bsq_pkg::WAIT_OT ##1
    state_reg == bsq_pkg::ST_INRUSH);

endmodule

//--- design/bsq_pkg.sv
// Shared constants and types for the boost start-up sequencer
package bsq_pkg;

  // Timing base
  localparam int CLK_PERIOD_NS  = 50;
  localparam int T_INRUSH_NS    = 2_048_000;
  localparam int T_SWEN_NS      = 128_000;
  localparam int T_SOFT_NS      = 2_048_000;
  localparam int T_NORMAL_NS    = 8_256_000;
  localparam int T_MIN_OFF_NS   = 100;
  localparam int F_OSC_HZ       = 1_000_000;
  localparam int F_SYNC_DET_HZ  = 300_000;
  localparam int INRUSH_CYC     = T_INRUSH_NS / CLK_PERIOD_NS;
  localparam int SWEN_CYC       = T_SWEN_NS / CLK_PERIOD_NS;
  localparam int SOFT_CYC       = T_SOFT_NS / CLK_PERIOD_NS;
  localparam int NORMAL_CYC     = T_NORMAL_NS / CLK_PERIOD_NS;
  localparam int MIN_OFF_CYC    =
    (T_MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_PERIOD_CYC =
    (1_000_000_000 / F_OSC_HZ) / CLK_PERIOD_NS;
  localparam int SYNC_MAX_CYC   =
    (1_000_000_000 / F_SYNC_DET_HZ) / CLK_PERIOD_NS;

  // Current limit steps, percent
  localparam logic [6:0] LIMIT_0   = 7'h00;
  localparam logic [6:0] LIMIT_25  = 7'h19;
  localparam logic [6:0] LIMIT_50  = 7'h32;
  localparam logic [6:0] LIMIT_75  = 7'h4B;
  localparam logic [6:0] LIMIT_100 = 7'h64;

  // Register map
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STATUS  = 4'h4;
  localparam int          CTRL_SYNC_ALLOW_BIT = 0;
  localparam int          CTRL_RESTART_BIT    = 1;
  localparam logic        CTRL_SYNC_ALLOW_RST = 1'h1;
  localparam int          STAT_STATE_LSB  = 0;
  localparam int          STAT_WAIT_LSB   = 3;
  localparam int          STAT_LOCK_BIT   = 5;
  localparam int          STAT_SW_BIT     = 6;
  localparam int          STAT_IO_BIT     = 7;
  localparam int          STAT_LIMIT_LSB  = 8;
  localparam int          STAT_MON_LSB    = 16;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Pin synchroniser reset: shutdown high, sync idle high
  localparam logic [10:0] PIN_SYNC_RST = 11'h005;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_INRUSH = 3'b001,
    ST_SW_EN  = 3'b010,
    ST_SB25   = 3'b011,
    ST_SB50   = 3'b100,
    ST_SB75   = 3'b101,
    ST_NORMAL = 3'b110,
    ST_FAULT  = 3'b111
  } bsq_state_type;

  typedef enum logic [1:0] {
    WAIT_NONE = 2'b00,
    WAIT_UV   = 2'b01,
    WAIT_OV   = 2'b10,
    WAIT_OT   = 2'b11
  } bsq_wait_type;

  // Analog comparator outputs from the power stage
  typedef struct packed {
    logic supply_below_off;
    logic supply_at_on;
    logic overcurrent;
    logic overvoltage;
    logic output_recovered;
    logic overtemp;
    logic temp_recovered;
    logic above_target;
  } bsq_monitor_type;

endpackage

//--- sim/bsq_host_model.sv
// Host model for the shutdown, select and sync pins
module bsq_host_model (
  // Clock and requests
  input  wire logic aclk,
  input  wire logic run_req,
  input  wire logic sel_req,
  input  wire logic sync_req,
  // Device pins
  output logic      shutdown_input_n = 1'b1,
  output logic      select_in = 1'b0,
  output logic      sync_clock_input = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  int div = 0;
  always @(posedge aclk) begin
    shutdown_input_n <= !run_req;
    select_in        <= sel_req;
    div              <= (div == 9) ? 0 : div + 1;
    // 1 MHz when used, else held static high
    if (!sync_req)
      sync_clock_input <= 1'b1;
    else if (div == 9)
      sync_clock_input <= !sync_clock_input;
  end
endmodule

//--- sim/test_bsq_sequencer.sv
// Self-checking bench for the boost start-up sequencer
module test_bsq_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, brdy = 0, arv = 0;
  logic        rrdy = 0, run = 0, sel = 0, syn = 0, awr, wr, bv, arr, rv;
  logic        sd_n, sel_in, sync_in, lim, full, sw, io, z_oe, o_oe, sense;
  logic        s_aw, s_w, s_ar, s_b, s_r;
  logic [3:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0]  bresp, rresp;
  logic [6:0]  pct;
  logic        ce = 1'b1, zo, oo;
  logic [9:0]  snap;
  logic [33:0] exp_q [$];
  logic [15:0] flt [3] = '{16'h8040, 16'h0402, 16'h1008};
  int          num_errors = 0, samples_checked = 0, n = 0, k;
  bsq_pkg::bsq_monitor_type mon = '0;
  bsq_sequencer #(.INRUSH_CYC(40), .SOFT_CYC(40)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(ce), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .shutdown_input_n(sd_n), .select_in(sel_in),
    .sync_clock_input(sync_in), .monitor_in(mon),
    .supply_switch_limited(lim), .supply_switch_full(full),
    .switch_node(sw), .current_limit_pct(pct), .io_active(io),
    .feedback_pin_zero_out(zo), .feedback_pin_zero_oe_n(z_oe),
    .feedback_pin_one_out(oo), .feedback_pin_one_oe_n(o_oe),
    .feedback_sense_sel(sense));
  bsq_host_model i_host (.aclk(aclk), .run_req(run), .sel_req(sel),
    .sync_req(syn), .shutdown_input_n(sd_n), .select_in(sel_in),
    .sync_clock_input(sync_in));
  always #25 aclk = ~aclk;
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Handshakes sampled mid-cycle, equal to their value at the next edge
  task automatic tick;
    @(negedge aclk);
    s_aw = awv && awr;
    s_w = wv && wr;
    s_ar = arv && arr;
    s_b = bv && brdy;
    s_r = rv && rrdy;
    @(posedge aclk);
    n++;
    if (n > 9000) begin
      num_errors++;
      print_verdict();
    end
  endtask
  // Results checked by the watcher below, in issue order
  task automatic rd_chk(input logic [3:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    n = 0;
    do begin
      tick();
      if (s_ar)
        arv <= 1'b0;
    end while (!s_r);
    rrdy <= 1'b0;
    tick();
  endtask
  task automatic wr_chk(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    n = 0;
    do begin
      tick();
      if (s_aw)
        awv <= 1'b0;
      if (s_w)
        wv <= 1'b0;
    end while (!s_b);
    brdy <= 1'b0;
    tick();
  endtask
  always @(posedge aclk) begin
    if (bv && brdy)
      check({bresp, 32'h0}, exp_q.pop_front());
    if (rv && rrdy)
      check({rresp, rd}, exp_q.pop_front());
  end
  // Slack covers restarts whose start edge is not seen directly
  task automatic to_normal(input int slack);
    logic [6:0] st [4] = '{bsq_pkg::LIMIT_25, bsq_pkg::LIMIT_50,
                           bsq_pkg::LIMIT_75, bsq_pkg::LIMIT_100};
    if (slack == 0)
      n = 0;
    while (lim !== 1'b1) tick();
    if (slack == 0)
      n = 0;
    while (full !== 1'b1) tick();
    check(34'(n >= 40 && n <= 40 + slack), 34'h1);
    for (int i = 0; i < 4; i++) begin
      n = 0;
      while (pct !== st[i]) tick();
      check(34'(n), (i == 0) ? 34'd2561 : 34'd40);
    end
  endtask
  initial begin
    void'($urandom(88838));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    tick();
    rd_chk(4'h0, 34'h1);
    rd_chk(4'h8, {bsq_pkg::RESP_SLVERR, 32'h0});
    wr_chk(4'hC, 32'h0, bsq_pkg::RESP_SLVERR);
    check({full, lim, io, sw, z_oe, o_oe}, 6'h03);
    sel <= 1'($urandom);
    run <= 1'b1;
    to_normal(0);
    rd_chk(4'h4, 34'h64C6);
    repeat (2) begin
      sel <= !sel;
      repeat (5) tick();
      check({sense, z_oe, o_oe, zo, oo}, {sel, !sel, sel, 2'b00});
    end
    syn <= 1'b1;
    repeat (120) tick();
    rd_chk(4'h4, 34'h64E6);
    // Enable low must freeze the running pulse train too
    ce <= 1'b0;
    tick();
    snap = {sw, pct, io, full};
    repeat (30) tick();
    check({sw, pct, io, full}, snap);
    ce <= 1'b1;
    wr_chk(4'h0, 32'h0, bsq_pkg::RESP_OKAY);
    rd_chk(4'h0, 34'h0);
    rd_chk(4'h4, 34'h64C6);
    wr_chk(4'h0, 32'h1, bsq_pkg::RESP_OKAY);
    for (int p = 0; p < 2; p++) begin
      mon <= p ? 8'h01 : 8'h00;
      // A pulse begun before the skip may run up to 18 cycles
      repeat (24) tick();
      k = 0;
      repeat (40) begin
        tick();
        k += int'(sw);
      end
      check(34'(k == 0), 34'(p));
    end
    mon <= 8'h20;
    repeat (3) tick();
    mon <= 8'h00;
    n = 0;
    to_normal(4);
    wr_chk(4'h0, 32'h3, bsq_pkg::RESP_OKAY);
    to_normal(4);
    foreach (flt[i]) begin
      mon <= flt[i][15:8];
      n = 0;
      while (full !== 1'b0) tick();
      repeat (10) tick();
      check({lim, full, sw, io}, {3'b000, i != 0});
      mon <= flt[i][7:0];
      to_normal(0);
    end
    run <= 1'b0;
    n = 0;
    while (full !== 1'b0) tick();
    repeat (4) tick();
    check({full, lim, io, sw, z_oe, o_oe}, 6'h03);
    print_verdict();
  end
endmodule
